/* File: hdl/wfc_pkg.sv */
// Shared constants and types of the waveform fault and capture control block.
// Assumes a 32-bit AXI4-Lite register bus and 8-bit registers in the low byte lane.
package wfc_pkg;

  localparam int ADDR_W = 8;
  localparam int CAP_W  = 12;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_RUN_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_INPUT_A   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INPUT_B   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EXT_CFG   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CAP_HIGH  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAP_LOW   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MATRIX    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h1C;

  // Field positions
  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_AUTORUN_BIT = 2;
  localparam int IC_CAPEN_BIT     = 7;
  localparam int IC_SRC_BIT       = 6;
  localparam int IC_EDGE_BIT      = 5;
  localparam int IC_FILT_BIT      = 4;
  localparam int IC_MODE_MSB      = 3;
  localparam int IC_MODE_LSB      = 0;
  localparam int EXT_EDGE_A_BIT   = 3;
  localparam int EXT_EDGE_B_BIT   = 2;
  localparam int EXT_SRC_A_BIT    = 1;
  localparam int EXT_SRC_B_BIT    = 0;
  localparam int CAP_SOFT_BIT     = 7;
  localparam int IM_SYNC_BIT      = 5;
  localparam int IM_EVB_BIT       = 4;
  localparam int IM_EVA_BIT       = 3;

  // Reset values and masks
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] IM_WRITE_MASK = 8'h3B;
  localparam logic [7:0] EXT_WRITE_MASK = 8'h0F;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h05;

  // Noise filter depth in samples
  localparam int FILTER_SAMPLES = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Fault mode codes
  localparam logic [3:0] MODE_IGNORE       = 4'h0;
  localparam logic [3:0] MODE_DT_WAIT      = 4'h1;
  localparam logic [3:0] MODE_PULSE_WAIT   = 4'h2;
  localparam logic [3:0] MODE_PULSE_HOLD   = 4'h3;
  localparam logic [3:0] MODE_DEACTIVATE   = 4'h4;
  localparam logic [3:0] MODE_STOP_DT      = 4'h5;
  localparam logic [3:0] MODE_DT_WAIT_ALT  = 4'h6;
  localparam logic [3:0] MODE_HALT         = 4'h7;
  localparam logic [3:0] MODE_RETRIG       = 4'h8;
  localparam logic [3:0] MODE_RETRIG_FIX   = 4'h9;
  localparam logic [3:0] MODE_RETRIG_OFF   = 4'hE;

  // Decoded action offered to the waveform engine
  typedef enum logic [3:0] {
    ACT_NONE         = 4'h0,
    ACT_JUMP_DT_WAIT = 4'h1,
    ACT_PULSE_WAIT   = 4'h2,
    ACT_PULSE_HOLD   = 4'h3,
    ACT_DEACTIVATE   = 4'h4,
    ACT_STOP_DT      = 4'h5,
    ACT_HALT         = 4'h6,
    ACT_RETRIG       = 4'h7,
    ACT_RETRIG_FIX   = 4'h8,
    ACT_RETRIG_OFF   = 4'h9
  } wfc_action_t;

  // Input candidates; bit index equals the source select code
  typedef struct packed {
    logic comp2;
    logic altPin;
    logic comp1;
    logic mainPin;
  } wfc_src_t;

  typedef struct packed {
    logic [1:0] srcSel;
    logic [1:0] edgeSel;
    logic       filtEn;
  } wfc_in_cfg_t;

  typedef struct packed {
    logic evt;
    logic active;
  } wfc_in_res_t;

  typedef struct packed {
    wfc_action_t action;
    logic        evt;
    logic        active;
  } wfc_fault_t;

endpackage : wfc_pkg

/* File: hdl/wfc_input_block.sv */
// One retrigger/fault input block: source select, noise filter, edge/level detect.
// Assumes the candidate inputs are already synchronous to clk.
`timescale 1ns/10ps
module wfc_input_block
  import wfc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire wfc_src_t    srcs,
  input  wire wfc_in_cfg_t cfg,
  output wfc_in_res_t      res
);

  typedef struct packed {
    logic [FILTER_SAMPLES-1:0] hist;
    logic                      filt;
    wfc_in_res_t               res;
  } wfc_blk_state_t;

  wfc_blk_state_t q;
  wfc_blk_state_t d;
  logic           raw;

  always_comb begin
    d   = q;
    raw = srcs[cfg.srcSel];
    d.hist = {q.hist[FILTER_SAMPLES-2:0], raw};
    // Filter trades three cycles of latency for glitch immunity
    if (cfg.filtEn) begin
      if (&d.hist) begin
        d.filt = 1'b1;
      end else if (~|d.hist) begin
        d.filt = 1'b0;
      end
    end else begin
      d.filt = raw;
    end
    unique case (cfg.edgeSel)
      2'b00: begin
        d.res.evt    = q.filt & ~d.filt;
        d.res.active = ~d.filt;
      end
      2'b01: begin
        d.res.evt    = ~q.filt & d.filt;
        d.res.active = d.filt;
      end
      2'b10: begin
        d.res.evt    = q.filt ^ d.filt;
        d.res.active = 1'b0;
      end
      default: begin
        // Reserved code stays quiet
        d.res.evt    = 1'b0;
        d.res.active = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign res = q.res;

endmodule : wfc_input_block

/* File: hdl/wfc_top.sv */
// Run control, two fault/retrigger inputs, 12-bit capture and output matrix.
// Assumes an AXI4-Lite master, a free counter and ramp number from the generator.
//
// Function
// - Writing run bit starts the channel
// - Run bit overrides autorun follow bit
// - Two identical input blocks A and B
// - Capture enable lets input events capture counter
// - Source select low bit, high in extended
// - Edge select low bit, high in extended
// - Filter needs four equal samples to change
// - Modes 0,1,6,2,3: ignore, stop, pulse actions
// - Modes 4,5,7: deactivate, insert dead-time, halt
// - Modes 8,9,14: edge and fixed retrigger
// - Soft trigger bit captures counter at once
// - Soft bit reads one after software capture
// - Enabled input event loads counter into capture
// - Capture is 12 bits, high nibble plus byte
// - Shared temporary high byte makes reads atomic
// - Matrix bits 7..4 drive output B per ramp
// - Matrix bits 3..0 drive output A per ramp
// - Sync error flag with enable raises request
// - Block B event with enable raises request
// - Autorun follows the preceding channel run
// - Source codes: main, comparator1, alternate, comparator2
// - Edge codes: falling, rising, toggle, reserved
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module wfc_top
  import wfc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              masterRun,
  input  wire logic              syncErrFlag,
  input  wire logic [CAP_W-1:0]  counterValue,
  input  wire logic [1:0]        rampNum,
  input  wire wfc_src_t          inputSrcs,
  output logic                   runActive,
  output logic                   outAPin,
  output logic                   outBPin,
  output logic                   outAMirrorPin,
  output logic                   outBMirrorPin,
  output wfc_fault_t             faultA,
  output wfc_fault_t             faultB,
  output logic                   syncErrIrq,
  output logic                   eventAIrq,
  output logic                   eventBIrq
);

  typedef struct packed {
    logic              awHave;
    logic [ADDR_W-1:0] awAddr;
    logic              awReady;
    logic              wHave;
    logic [7:0]        wData;
    logic              wLane0;
    logic              wReady;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic              rValid;
    logic [7:0]        rData;
    logic [1:0]        rResp;
    logic              runBit;
    logic              autoBit;
    logic [7:0]        inCtlA;
    logic [7:0]        inCtlB;
    logic [7:0]        extCfg;
    logic [7:0]        matrix;
    logic [7:0]        irqMask;
    logic [CAP_W-1:0]  capture;
    logic              softCap;
    logic [7:0]        tempHigh;
    logic              runActive;
    logic              outA;
    logic              outB;
    wfc_fault_t        fa;
    wfc_fault_t        fb;
    logic              syncIrq;
    logic              evAIrq;
    logic              evBIrq;
  } wfc_state_t;

  localparam wfc_state_t RST_STATE = '{
    awReady: 1'b1,
    wReady:  1'b1,
    arReady: 1'b1,
    default: '0
  };

  wfc_state_t  q;
  wfc_state_t  d;
  wfc_in_cfg_t cfgA;
  wfc_in_cfg_t cfgB;
  wfc_in_res_t resA;
  wfc_in_res_t resB;
  logic        softTrig;
  logic        hwCapture;
  logic        deactA;
  logic        deactB;
  logic        wrErr;
  logic        rdErr;
  logic [7:0]  rdByte;

  function automatic wfc_action_t decodeMode(input logic [3:0] mode);
    wfc_action_t act;
    act = ACT_NONE;
    unique case (mode)
      MODE_IGNORE:      act = ACT_NONE;
      MODE_DT_WAIT:     act = ACT_JUMP_DT_WAIT;
      MODE_DT_WAIT_ALT: act = ACT_JUMP_DT_WAIT;
      MODE_PULSE_WAIT:  act = ACT_PULSE_WAIT;
      MODE_PULSE_HOLD:  act = ACT_PULSE_HOLD;
      MODE_DEACTIVATE:  act = ACT_DEACTIVATE;
      MODE_STOP_DT:     act = ACT_STOP_DT;
      MODE_HALT:        act = ACT_HALT;
      MODE_RETRIG:      act = ACT_RETRIG;
      MODE_RETRIG_FIX:  act = ACT_RETRIG_FIX;
      MODE_RETRIG_OFF:  act = ACT_RETRIG_OFF;
      // Reserved codes act as ignore
      default:          act = ACT_NONE;
    endcase
    return act;
  endfunction : decodeMode

  // Both blocks share one layout; the extended register holds the high bits
  always_comb begin
    cfgA.srcSel  = {q.extCfg[EXT_SRC_A_BIT], q.inCtlA[IC_SRC_BIT]};
    cfgA.edgeSel = {q.extCfg[EXT_EDGE_A_BIT], q.inCtlA[IC_EDGE_BIT]};
    cfgA.filtEn  = q.inCtlA[IC_FILT_BIT];
    cfgB.srcSel  = {q.extCfg[EXT_SRC_B_BIT], q.inCtlB[IC_SRC_BIT]};
    cfgB.edgeSel = {q.extCfg[EXT_EDGE_B_BIT], q.inCtlB[IC_EDGE_BIT]};
    cfgB.filtEn  = q.inCtlB[IC_FILT_BIT];
  end

  wfc_input_block u_block_a (
    .clk  (clk),
    .srst (srst),
    .srcs (inputSrcs),
    .cfg  (cfgA),
    .res  (resA)
  );

  wfc_input_block u_block_b (
    .clk  (clk),
    .srst (srst),
    .srcs (inputSrcs),
    .cfg  (cfgB),
    .res  (resB)
  );

  always_comb begin
    d         = q;
    softTrig  = 1'b0;
    wrErr     = 1'b0;
    rdErr     = 1'b0;
    rdByte    = REG_RESET;

    // Write channels taken independently
    if (s_axi_awvalid && q.awReady) begin
      d.awHave  = 1'b1;
      d.awAddr  = s_axi_awaddr;
      d.awReady = 1'b0;
    end
    if (s_axi_wvalid && q.wReady) begin
      d.wHave  = 1'b1;
      d.wData  = s_axi_wdata[7:0];
      d.wLane0 = s_axi_wstrb[0];
      d.wReady = 1'b0;
    end

    // Register write once both halves are held
    if (q.awHave && q.wHave && !q.bValid) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bValid = 1'b1;
      unique case (q.awAddr)
        OFS_RUN_CTRL: begin
          if (q.wLane0) begin
            d.runBit  = q.wData[CTRL_RUN_BIT];
            d.autoBit = q.wData[CTRL_AUTORUN_BIT];
          end
        end
        OFS_INPUT_A: begin
          if (q.wLane0) begin
            d.inCtlA = q.wData;
          end
        end
        OFS_INPUT_B: begin
          if (q.wLane0) begin
            d.inCtlB = q.wData;
          end
        end
        OFS_EXT_CFG: begin
          if (q.wLane0) begin
            d.extCfg = q.wData & EXT_WRITE_MASK;
          end
        end
        OFS_CAP_HIGH: begin
          softTrig = q.wLane0 & q.wData[CAP_SOFT_BIT];
        end
        OFS_CAP_LOW: begin
          // Read-only, write dropped
          softTrig = 1'b0;
        end
        OFS_MATRIX: begin
          if (q.wLane0) begin
            d.matrix = q.wData;
          end
        end
        OFS_IRQ_MASK: begin
          if (q.wLane0) begin
            d.irqMask = q.wData & IM_WRITE_MASK;
          end
        end
        default: begin
          wrErr = 1'b1;
        end
      endcase
      d.bResp = wrErr ? RESP_SLVERR : RESP_OKAY;
    end
    if (q.bValid && s_axi_bready) begin
      d.bValid  = 1'b0;
      d.awReady = 1'b1;
      d.wReady  = 1'b1;
    end

    // Read path, one cycle to answer
    if (s_axi_arvalid && q.arReady) begin
      d.arReady = 1'b0;
      d.rValid  = 1'b1;
      unique case (s_axi_araddr)
        OFS_RUN_CTRL: begin
          rdByte[CTRL_RUN_BIT]     = q.runBit;
          rdByte[CTRL_AUTORUN_BIT] = q.autoBit;
        end
        OFS_INPUT_A:  rdByte = q.inCtlA;
        OFS_INPUT_B:  rdByte = q.inCtlB;
        OFS_EXT_CFG:  rdByte = q.extCfg;
        // High byte comes from the latch, not the live capture
        OFS_CAP_HIGH: rdByte = q.tempHigh;
        OFS_CAP_LOW: begin
          rdByte     = q.capture[7:0];
          d.tempHigh = {q.softCap, 3'b000, q.capture[CAP_W-1:8]};
        end
        OFS_MATRIX:   rdByte = q.matrix;
        OFS_IRQ_MASK: rdByte = q.irqMask;
        default: begin
          rdErr = 1'b1;
        end
      endcase
      d.rData = rdByte;
      d.rResp = rdErr ? RESP_SLVERR : RESP_OKAY;
    end
    if (q.rValid && s_axi_rready) begin
      d.rValid  = 1'b0;
      d.arReady = 1'b1;
    end

    // Capture; a software trigger wins over a same-cycle input event
    hwCapture = (resA.evt & q.inCtlA[IC_CAPEN_BIT])
              | (resB.evt & q.inCtlB[IC_CAPEN_BIT]);
    if (softTrig) begin
      d.capture = counterValue;
      d.softCap = 1'b1;
    end else if (hwCapture) begin
      d.capture = counterValue;
      d.softCap = 1'b0;
    end

    // Run bit prevails; autorun only follows the master
    d.runActive = q.runBit | (q.autoBit & masterRun);

    // Fault decode per block
    d.fa.action = decodeMode(q.inCtlA[IC_MODE_MSB:IC_MODE_LSB]);
    d.fa.evt    = resA.evt;
    d.fa.active = resA.active;
    d.fb.action = decodeMode(q.inCtlB[IC_MODE_MSB:IC_MODE_LSB]);
    d.fb.evt    = resB.evt;
    d.fb.active = resB.active;

    // Deactivating modes force outputs low but leave timing alone
    deactA = resA.active & ((d.fa.action == ACT_DEACTIVATE)
                          | (d.fa.action == ACT_RETRIG_OFF));
    deactB = resB.active & ((d.fb.action == ACT_DEACTIVATE)
                          | (d.fb.action == ACT_RETRIG_OFF));
    d.outA = ~(deactA | deactB) & q.matrix[{1'b0, rampNum}];
    d.outB = ~(deactA | deactB) & q.matrix[{1'b1, rampNum}];

    // Interrupt requests; flags themselves live elsewhere
    d.syncIrq = q.irqMask[IM_SYNC_BIT] & syncErrFlag;
    d.evAIrq  = q.irqMask[IM_EVA_BIT] & resA.evt;
    d.evBIrq  = q.irqMask[IM_EVB_BIT] & resB.evt;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awReady;
  assign s_axi_wready  = q.wReady;
  assign s_axi_bresp   = q.bResp;
  assign s_axi_bvalid  = q.bValid;
  assign s_axi_arready = q.arReady;
  assign s_axi_rdata   = {24'h00_0000, q.rData};
  assign s_axi_rresp   = q.rResp;
  assign s_axi_rvalid  = q.rValid;
  assign runActive     = q.runActive;
  assign outAPin       = q.outA;
  assign outBPin       = q.outB;
  // Mirror pins follow the same matrix bit
  assign outAMirrorPin = q.outA;
  assign outBMirrorPin = q.outB;
  assign faultA        = q.fa;
  assign faultB        = q.fb;
  assign syncErrIrq    = q.syncIrq;
  assign eventAIrq     = q.evAIrq;
  assign eventBIrq     = q.evBIrq;

endmodule : wfc_top

/* File: verification/wfc_stage_model.sv */
// Far side model: generator counter and the four candidate input lines.
// Assumes the bench commands count and line levels; both are registered once on clk.
`timescale 1ns/10ps
module wfc_stage_model
  import wfc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [CAP_W-1:0] load,
  input  wire wfc_src_t         pins,
  output logic [CAP_W-1:0]      counterValue,
  output logic [1:0]            rampNum,
  output wfc_src_t              inputSrcs
);
  // Ramp tied to counter top bits, so one held count fixes both
  assign rampNum = counterValue[CAP_W-1:CAP_W-2];
  always_ff @(posedge clk) begin
    inputSrcs <= pins;
    counterValue <= srst ? '0 : load;
  end
endmodule : wfc_stage_model

/* File: verification/wfc_top_sva.sv */
// Checker on the control block ports: bus answers, output pairs, requests.
// Assumes one clock domain with synchronous active-high srst.
`timescale 1ns/10ps
module wfc_top_sva
  import wfc_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        syncErrFlag,
  input wire logic        syncErrIrq,
  input wire logic        eventBIrq,
  input wire logic        outAPin,
  input wire logic        outAMirrorPin,
  input wire logic        outBPin,
  input wire logic        outBMirrorPin,
  input wire wfc_fault_t  faultA,
  input wire wfc_fault_t  faultB
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after take");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
    else $error("read data upper lanes not zero");
  a_mirror_a: assert property (outAPin == outAMirrorPin)
    else $error("output a mirror differs");
  a_mirror_b: assert property (outBPin == outBMirrorPin)
    else $error("output b mirror differs");
  a_sync_irq: assert property (syncErrIrq |-> $past(syncErrFlag))
    else $error("sync request without flag");
  a_evb_pulse: assert property (eventBIrq |=> !eventBIrq)
    else $error("event b request longer than one cycle");
  a_evt_pulse: assert property (faultA.evt |=> !faultA.evt)
    else $error("event a longer than one cycle");
  a_evb_cause: assert property (eventBIrq |-> faultB.evt)
    else $error("event b request without event");
endmodule : wfc_top_sva

/* File: verification/tb_top.sv */
// Self-checking bench for the control block with an AXI4-Lite master.
// Assumes the far side model supplies counter, ramp and input lines.
`timescale 1ns/10ps
module tb_top;
  import wfc_pkg::*;
  logic              clk, srst, masterRun, syncErrFlag, seen, irq;
  logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic              runActive, outAPin, outBPin, outAMirrorPin, outBMirrorPin;
  logic              syncErrIrq, eventAIrq, eventBIrq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rampNum, bLast, rLast;
  logic [CAP_W-1:0]  counterValue, load;
  wfc_src_t          inputSrcs, pins;
  wfc_fault_t        faultA, faultB;
  int                failCount, compares, cyc, lag;

  wfc_top u_dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .masterRun, .syncErrFlag, .counterValue, .rampNum, .inputSrcs, .runActive,
    .outAPin, .outBPin, .outAMirrorPin, .outBMirrorPin, .faultA, .faultB, .syncErrIrq,
    .eventAIrq, .eventBIrq);
  wfc_stage_model u_model (.clk, .srst, .load, .pins, .counterValue, .rampNum, .inputSrcs);

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task automatic giveVerdict();
    if (failCount == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : giveVerdict

  // Ceiling well above the whole sequence length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failCount++;
      giveVerdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rst();
    @(posedge clk);
    srst <= 1;
    repeat (10) @(posedge clk);
    srst <= 0;
    repeat (2) @(posedge clk);
  endtask : rst

  // Trailing edge keeps bready from being assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= (lag == 0);
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    repeat (lag) @(posedge clk);
    s_axi_bready <= 1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    bLast = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= (lag == 0);
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    repeat (lag) @(posedge clk);
    s_axi_rready <= 1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rLast = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge clk);
  endtask : rd

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, rdv, {24'h0, e});
  endtask : rchk

  function automatic wfc_action_t act(input int m);
    case (m)
      1, 6: return ACT_JUMP_DT_WAIT;
      2: return ACT_PULSE_WAIT;
      3: return ACT_PULSE_HOLD;
      4: return ACT_DEACTIVATE;
      5: return ACT_STOP_DT;
      7: return ACT_HALT;
      8: return ACT_RETRIG;
      9: return ACT_RETRIG_FIX;
      14: return ACT_RETRIG_OFF;
      default: return ACT_NONE;
    endcase
  endfunction : act

  task automatic t_regs();
    logic [7:0] ad [5] = '{OFS_INPUT_A, OFS_INPUT_B, OFS_EXT_CFG, OFS_MATRIX, OFS_IRQ_MASK};
    logic [7:0] ex [5] = '{8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h3B};
    for (int i = 0; i < 5; i++) begin
      wr(ad[i], 8'hFF);
      rchk("reg", ad[i], ex[i]);
    end
    chk("bresp", bLast, RESP_OKAY);
    wr(OFS_CAP_LOW, 8'hFF);
    wr(OFS_CAP_HIGH, 8'h7F);
    rchk("cap lo ro", OFS_CAP_LOW, 8'h00);
    rchk("cap hi ro", OFS_CAP_HIGH, 8'h00);
    rd(8'h20);
    chk("rresp", rLast, RESP_SLVERR);
    wr(8'h20, 8'h01);
    chk("bresp", bLast, RESP_SLVERR);
    rst();
    for (int a = 0; a < 32; a += 4) rchk("reset", a[7:0], REG_RESET);
  endtask : t_regs

  task automatic t_run();
    wr(OFS_RUN_CTRL, 8'h04);
    chk("run", runActive, 1'b0);
    masterRun <= 1;
    repeat (3) @(posedge clk);
    chk("run", runActive, 1'b1);
    masterRun <= 0;
    repeat (3) @(posedge clk);
    chk("run", runActive, 1'b0);
    wr(OFS_RUN_CTRL, 8'h05);
    chk("run", runActive, 1'b1);
    wr(OFS_RUN_CTRL, 8'h00);
    chk("run", runActive, 1'b0);
  endtask : t_run

  task automatic t_matrix();
    logic [7:0] m = 8'h96;
    wr(OFS_MATRIX, m);
    for (int r = 0; r < 4; r++) begin
      load <= {r[1:0], 10'h0};
      repeat (4) @(posedge clk);
      chk("out a", outAPin, m[r]);
      chk("out b", outBPin, m[4+r]);
    end
    pins.mainPin <= 1;
    wr(OFS_INPUT_A, 8'h24);
    repeat (4) @(posedge clk);
    chk("deact", outBPin, 1'b0);
    chk("active", faultA.active, 1'b1);
    wr(OFS_INPUT_A, 8'h20);
    repeat (4) @(posedge clk);
    chk("ignore", outBPin, 1'b1);
    pins.mainPin <= 0;
  endtask : t_matrix

  task automatic t_modes();
    for (int m = 0; m < 16; m++) begin
      if (m inside {[10:13], 15}) continue;
      wr(OFS_INPUT_A, m[7:0]);
      repeat (2) @(posedge clk);
      chk("action", faultA.action, act(m));
    end
  endtask : t_modes

  task automatic t_capture();
    lag = 2;
    load <= 12'hABC;
    wr(OFS_CAP_HIGH, 8'h80);
    rchk("cap lo", OFS_CAP_LOW, 8'hBC);
    rchk("cap hi", OFS_CAP_HIGH, 8'h8A);
    load <= 12'h123;
    wr(OFS_CAP_HIGH, 8'h80);
    rchk("cap hi", OFS_CAP_HIGH, 8'h8A);
    rchk("cap lo", OFS_CAP_LOW, 8'h23);
    rchk("cap hi", OFS_CAP_HIGH, 8'h81);
    lag = 0;
  endtask : t_capture

  task automatic t_events();
    logic [1:0] e;
    logic       init;
    wr(OFS_IRQ_MASK, 8'h10);
    for (int i = 0; i < 4; i++) begin
      e = (i == 3) ? 2'h0 : i[1:0];
      init = (e == 2'h0);
      pins <= {4{init}};
      load <= {8'h5A, 2'h0, i[1:0]};
      wr(OFS_EXT_CFG, {5'h0, e[1], 1'b0, i[1]});
      wr(OFS_INPUT_B, {1'b1, i[0], e[0], 1'b0, MODE_RETRIG});
      pins[i] <= !init;
      seen = 0;
      irq = 0;
      repeat (12) begin
        @(posedge clk);
        seen |= faultB.evt === 1'b1;
        irq |= eventBIrq === 1'b1;
      end
      chk("evt b", seen, 1'b1);
      chk("irq b", irq, 1'b1);
      chk("action b", faultB.action, ACT_RETRIG);
      chk("active b", faultB.active, e != 2'h2);
      rchk("cap lo", OFS_CAP_LOW, {6'h28, i[1:0]});
      rchk("cap hi", OFS_CAP_HIGH, 8'h05);
    end
    wr(OFS_INPUT_B, 8'h48);
    load <= 12'h000;
    pins[3] <= 1;
    repeat (6) @(posedge clk);
    pins[3] <= 0;
    repeat (12) @(posedge clk);
    rchk("no cap", OFS_CAP_LOW, 8'hA3);
  endtask : t_events

  task automatic lat(input logic f, output int n);
    wr(OFS_INPUT_A, {3'h5, f, MODE_RETRIG});
    repeat (8) @(posedge clk);
    pins.mainPin <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (faultA.evt !== 1'b1 && n < 20);
    chk("irq a", eventAIrq, 1'b1);
    pins.mainPin <= 0;
    repeat (8) @(posedge clk);
  endtask : lat

  task automatic t_filter();
    int n0, n1;
    wr(OFS_EXT_CFG, 8'h00);
    wr(OFS_IRQ_MASK, 8'h08);
    pins <= '0;
    lat(1'b0, n0);
    lat(1'b1, n1);
    chk("filter", n1 - n0, FILTER_SAMPLES - 1);
    pins.mainPin <= 1;
    repeat (2) @(posedge clk);
    pins.mainPin <= 0;
    seen = 0;
    repeat (10) begin
      @(posedge clk);
      seen |= faultA.evt === 1'b1;
    end
    chk("glitch", seen, 1'b0);
  endtask : t_filter

  task automatic t_sync();
    wr(OFS_IRQ_MASK, 8'h20);
    syncErrFlag <= 1;
    repeat (3) @(posedge clk);
    chk("sync irq", syncErrIrq, 1'b1);
    wr(OFS_IRQ_MASK, 8'h00);
    chk("sync irq", syncErrIrq, 1'b0);
    syncErrFlag <= 0;
  endtask : t_sync

  initial begin
    {srst, masterRun, syncErrFlag} = 3'h4;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h1;
    load = '0;
    pins = '0;
    rst();
    t_regs();
    t_run();
    t_matrix();
    t_modes();
    t_capture();
    t_events();
    t_filter();
    t_sync();
    giveVerdict();
  end
endmodule : tb_top

bind wfc_top wfc_top_sva u_sva (.clk, .srst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .syncErrFlag,
  .syncErrIrq, .eventBIrq, .outAPin, .outAMirrorPin, .outBPin, .outBMirrorPin, .faultA, .faultB);
